// [include/hbs_pkg.sv]
// Constants for the bridge driver serial frame logic.
// Assumes a single system clock far faster than the serial clock.
package hbs_pkg;
	// ==========================================================
	// Frame geometry
	localparam int CNT_W = 5;
	localparam logic [4:0] ADDR_BITS = 5'h02;
	localparam logic [4:0] INSTR_LAST = 5'h07;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] CNT_MAX = 5'h1f;
	// ==========================================================
	// Serial rate limit of the master
	localparam int SCK_MAX_KBAUD = 2000;
	localparam int MCLK_MHZ = 250;
	localparam int SCK_MIN_HALF_CYC = (MCLK_MHZ * 1000) / (2 * SCK_MAX_KBAUD);
	// ==========================================================
	// Instruction codes (chip address in bits 7:6 excluded)
	localparam logic [5:0] OP_RD_ID = 6'h00;
	localparam logic [5:0] OP_RD_REV = 6'h03;
	localparam logic [5:0] OP_RD_DIAG = 6'h09;
	localparam logic [5:0] OP_RD_CFG = 6'h30;
	localparam logic [5:0] OP_RD_SUPPLY = 6'h3c;
	localparam logic [5:0] OP_WR_CFG = 6'h28;
	localparam logic [5:0] OP_WR_SUPPLY = 6'h18;
	// ==========================================================
	// Output byte values and default chip address
	localparam logic [7:0] VERIFY_PATTERN = 8'h2a;
	localparam logic [7:0] DATA_WR_ACK = 8'h00;
	localparam logic [7:0] DATA_UNUSED = 8'hff;
	localparam logic [1:0] CHIP_ADDR_DEF = 2'h0;
	// ==========================================================
	// Values after reset
	localparam logic [4:0] RST_CNT = 5'h00;
	localparam logic [15:0] RST_RX = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_PINS = 3'h4;
endpackage : hbs_pkg

// [design/hbs_sync.sv]
// Two-stage synchroniser for the serial pins.
// Assumes pins are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module hbs_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk, // System clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [W-1:0] pin_in, // Raw pins
	output logic [W-1:0] pin_sync // Synchronised pins
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign pin_sync = sync_q;
endmodule : hbs_sync
`default_nettype wire

// [design/hbs_decode.sv]
// Instruction decoder: classifies an instruction and picks the reply byte.
// Assumes register read values are steady on mclk.
`timescale 1ns/1ps
`default_nettype none
module hbs_decode (
	input wire logic [5:0] op, // Instruction field
	input wire logic [7:0] id_val, // Identifier value
	input wire logic [7:0] rev_val, // Revision value
	input wire logic [7:0] diag_val, // Diagnostics value
	input wire logic [7:0] cfg_val, // Configuration value
	input wire logic [7:0] supply_val, // Supply monitor value
	output logic known, // Code is assigned
	output logic is_write, // Code is a write
	output logic [7:0] reply // Data byte to send
);
	always_comb begin
		known = 1'b1;
		is_write = 1'b0;
		reply = hbs_pkg::DATA_UNUSED;
		case (op)
			hbs_pkg::OP_RD_ID: reply = id_val;
			hbs_pkg::OP_RD_REV: reply = rev_val;
			hbs_pkg::OP_RD_DIAG: reply = diag_val;
			hbs_pkg::OP_RD_CFG: reply = cfg_val;
			hbs_pkg::OP_RD_SUPPLY: reply = supply_val;
			hbs_pkg::OP_WR_CFG, hbs_pkg::OP_WR_SUPPLY: begin
				is_write = 1'b1;
				reply = hbs_pkg::DATA_WR_ACK;
			end
			default: begin
				known = 1'b0;
				reply = hbs_pkg::DATA_UNUSED;
			end
		endcase
	end
endmodule : hbs_decode
`default_nettype wire

// [design/hbs_spi_frame.sv]
// Serial slave frame logic of a motor bridge driver.
// Assumes the master keeps the serial rate within the limit, so mclk
// oversamples every serial edge after a two-stage synchroniser.
`timescale 1ns/1ps
`default_nettype none
module hbs_spi_frame #(
	parameter logic [1:0] CHIP_ADDR = hbs_pkg::CHIP_ADDR_DEF
) (
	input wire logic mclk, // System clock, 250 MHz
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic sck, // Serial clock from master
	input wire logic ss_n, // Slave select, active low
	input wire logic si, // Serial data in
	output logic so_o, // Serial data out value
	output logic so_oe, // Serial data out enable
	input wire logic proc_busy, // Previous instruction still processing
	input wire logic [7:0] id_val, // Identifier register value
	input wire logic [7:0] rev_val, // Revision register value
	input wire logic [7:0] diag_val, // Diagnostics register value
	input wire logic [7:0] cfg_val, // Configuration register value
	input wire logic [7:0] supply_val, // Supply monitor register value
	output logic exec_stb, // Valid instruction commit pulse
	output logic exec_wr, // Committed instruction is a write
	output logic [7:0] exec_instr, // Committed instruction byte
	output logic [7:0] exec_data, // Write data, zero for reads
	output logic trans_fail // Failure flag awaiting transmission
);
	// ==========================================================
	// State
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_SHIFT,
		ST_SKIP
	} hbs_fsm_t;

	typedef struct packed {
		hbs_fsm_t state;
		logic [4:0] cnt;
		logic [15:0] rx;
		logic [7:0] dbyte;
		logic so;
		logic oe;
		logic flag;
		logic sent;
		logic busy_seen;
		logic sck_prev;
		logic ss_prev;
		logic exec_stb;
		logic exec_wr;
		logic [7:0] exec_instr;
		logic [7:0] exec_data;
	} hbs_state_t;

	localparam hbs_state_t RST_STATE = '{
		state: ST_IDLE,
		cnt: hbs_pkg::RST_CNT,
		rx: hbs_pkg::RST_RX,
		dbyte: hbs_pkg::RST_BYTE,
		so: 1'b0,
		oe: 1'b0,
		flag: 1'b0,
		sent: 1'b0,
		busy_seen: 1'b0,
		sck_prev: 1'b0,
		ss_prev: 1'b1,
		exec_stb: 1'b0,
		exec_wr: 1'b0,
		exec_instr: hbs_pkg::RST_BYTE,
		exec_data: hbs_pkg::RST_BYTE
	};

	hbs_state_t q;
	hbs_state_t d;

	// ==========================================================
	// Pin synchronisation; sck comes from the master only
	logic [2:0] pins_s;
	logic ss_s;
	logic sck_s;
	logic si_s;

	hbs_sync #(
		.W(3),
		.RST_VAL(hbs_pkg::RST_PINS)
	) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.pin_in({ss_n, sck, si}),
		.pin_sync(pins_s)
	);

	assign ss_s = pins_s[2];
	assign sck_s = pins_s[1];
	assign si_s = pins_s[0];

	logic sck_rise;
	logic sck_fall;
	logic ss_rise;
	logic active;

	assign active = !ss_s;
	assign sck_rise = active && sck_s && !q.sck_prev;
	assign sck_fall = active && !sck_s && q.sck_prev;
	assign ss_rise = ss_s && !q.ss_prev;

	// ==========================================================
	// Decoder; at the eighth falling edge the byte is still in flight
	logic [7:0] instr_w;
	logic known;
	logic is_write;
	logic [7:0] reply;

	assign instr_w = (q.cnt == hbs_pkg::INSTR_LAST) ? {q.rx[6:0], si_s} : q.rx[15:8];

	hbs_decode u_dec (
		.op(instr_w[5:0]),
		.id_val(id_val),
		.rev_val(rev_val),
		.diag_val(diag_val),
		.cfg_val(cfg_val),
		.supply_val(supply_val),
		.known(known),
		.is_write(is_write),
		.reply(reply)
	);

	logic [7:0] verify_w;
	logic frame_ok;
	logic commit;

	assign verify_w = {hbs_pkg::VERIFY_PATTERN[7:1], q.flag};
	assign frame_ok = (q.cnt == hbs_pkg::FRAME_BITS) && known && !q.busy_seen;
	assign commit = ss_rise && (q.state == ST_SHIFT || q.state == ST_ADDR);

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		d.sck_prev = sck_s;
		d.ss_prev = ss_s;
		d.exec_stb = 1'b0;
		if (ss_s) begin
			// Idle and tristate whenever deselected
			d.state = ST_IDLE;
			d.oe = 1'b0;
			d.cnt = hbs_pkg::RST_CNT;
			d.busy_seen = 1'b0;
			if (commit) begin
				// Set wins over clear of the failure flag
				d.flag = !frame_ok || (q.flag && !q.sent);
				d.sent = 1'b0;
				d.exec_stb = frame_ok;
				d.exec_wr = is_write;
				d.exec_instr = q.rx[15:8];
				d.exec_data = is_write ? q.rx[7:0] : hbs_pkg::RST_BYTE;
			end
		end else begin
			if (proc_busy) begin
				d.busy_seen = 1'b1;
			end
			if (q.state == ST_IDLE) begin
				d.state = ST_ADDR;
			end
			if (sck_fall) begin
				d.rx = {q.rx[14:0], si_s};
				// Saturate so a long frame never wraps back to sixteen
				if (q.cnt != hbs_pkg::CNT_MAX) begin
					d.cnt = q.cnt + 5'h01;
				end
				if (q.cnt == hbs_pkg::ADDR_BITS - 5'h01 && q.state != ST_SKIP) begin
					d.state = ({q.rx[0], si_s} == CHIP_ADDR) ? ST_SHIFT : ST_SKIP;
				end
				if (q.cnt == hbs_pkg::INSTR_LAST) begin
					d.dbyte = reply;
				end
			end
			if (sck_rise && q.state == ST_SHIFT) begin
				d.oe = 1'b1;
				if (q.cnt < hbs_pkg::INSTR_LAST + 5'h01) begin
					d.so = verify_w[3'(hbs_pkg::INSTR_LAST - q.cnt)];
				end else if (q.cnt < hbs_pkg::FRAME_BITS) begin
					d.so = q.dbyte[3'(hbs_pkg::FRAME_BITS - 5'h01 - q.cnt)];
				end
				if (q.cnt == hbs_pkg::INSTR_LAST) begin
					d.sent = 1'b1;
				end
			end
			if (q.state == ST_SKIP || q.state == ST_ADDR) begin
				d.oe = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	assign so_o = q.so;
	assign so_oe = q.oe;
	assign exec_stb = q.exec_stb;
	assign exec_wr = q.exec_wr;
	assign exec_instr = q.exec_instr;
	assign exec_data = q.exec_data;
	assign trans_fail = q.flag;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_verify_flag;
		sck_rise && q.state == ST_SHIFT && q.cnt == hbs_pkg::INSTR_LAST;
	endsequence

	sequence s_bad_end;
		commit && !frame_ok;
	endsequence

	sequence s_unused_load;
		sck_fall && q.state == ST_SHIFT && q.cnt == hbs_pkg::INSTR_LAST && !known;
	endsequence

	a_deselect_tristate: assert property (ss_s |=> !so_oe)
		else $error("Output driven while deselected");
	a_addr_tristate: assert property (q.state == ST_ADDR || q.state == ST_SKIP |-> ##1 !so_oe)
		else $error("Output driven during address or foreign frame");
	a_rx_sample: assert property (sck_fall |=> q.rx == {$past(q.rx[14:0]), $past(si_s)})
		else $error("Input not sampled on falling edge");
	a_so_steady: assert property (q.state == ST_SHIFT && !sck_rise |=> $stable(so_o))
		else $error("Output changed without rising edge");
	a_exec_commit: assert property (exec_stb |-> $past(ss_rise) && $past(frame_ok))
		else $error("Execution without valid frame end");
	a_flag_shift: assert property (s_verify_flag |=> so_oe && so_o == $past(q.flag))
		else $error("Failure flag not shifted at bit zero");
	a_flag_set: assert property (s_bad_end |=> trans_fail ##1 trans_fail)
		else $error("Invalid frame did not set failure flag");
	a_flag_hold: assert property (trans_fail && !q.sent |=> trans_fail)
		else $error("Failure flag cleared before being sent");
	a_unused_ff: assert property (s_unused_load |=> q.dbyte == hbs_pkg::DATA_UNUSED)
		else $error("Unused code reply not all ones");
	a_pattern_lead: assert property (sck_rise && q.state == ST_SHIFT && q.cnt == hbs_pkg::ADDR_BITS
		|=> so_oe && so_o)
		else $error("Verification pattern first bit wrong");
endmodule : hbs_spi_frame
`default_nettype wire

// [testbench/hbs_spi_master.sv]
// Serial master model that drives the frame logic's pins.
// Assumes mclk at 250 MHz; sck idles low and stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module hbs_spi_master (
	input wire logic mclk, // System clock
	output logic sck, // Serial clock
	output logic ss_n, // Select, active low
	output logic si, // Data to device
	input wire logic so_o, // Device output value
	input wire logic so_oe // Device output enable
);
	// ==========================================================
	// 64 mclk half period keeps the rate just under the limit
	localparam int HALF = 64;
	logic so_line;
	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
		si = 1'b0;
		so_line = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wait_clk
	// ==========================================================
	// One frame of nbits, MSB first; returns line values and enables
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx, output logic [15:0] oe);
		rx = 16'h0000;
		oe = 16'h0000;
		ss_n = 1'b0;
		wait_clk(HALF);
		for (int k = 0; k < nbits; k++) begin
			sck = 1'b1;
			si = tx[(15 - k) & 15];
			wait_clk(HALF);
			// A released line must not show the last value
			so_line = so_oe ? so_o : ~so_line;
			if (k < 16) begin
				rx[15 - k] = so_line;
				oe[15 - k] = so_oe;
			end
			sck = 1'b0;
			wait_clk(HALF);
		end
		ss_n = 1'b1;
		si = ~si;
	endtask : xfer
endmodule : hbs_spi_master
`default_nettype wire

// [testbench/hbs_spi_frame_tb_top.sv]
// Self-checking bench of the serial frame logic.
// Assumes the master model in hbs_spi_master.sv.
`timescale 1ns/1ps
`default_nettype none
module hbs_spi_frame_tb_top;
	logic mclk, reset_n, proc_busy, sck, ss_n, si, so_o, so_oe, exec_stb, exec_wr, trans_fail;
	logic [7:0] exec_instr, exec_data;
	logic [7:0] vals [5];
	logic [15:0] rx, oe;
	int bad_count, num_checks, n_exec, n0;
	hbs_spi_master u_hbs_spi_master (.mclk(mclk), .sck(sck), .ss_n(ss_n), .si(si), .so_o(so_o), .so_oe(so_oe));
	hbs_spi_frame u_hbs_spi_frame (.mclk(mclk), .reset_n(reset_n), .sck(sck), .ss_n(ss_n), .si(si),
		.so_o(so_o), .so_oe(so_oe), .proc_busy(proc_busy), .id_val(vals[0]), .rev_val(vals[1]),
		.diag_val(vals[2]), .cfg_val(vals[3]), .supply_val(vals[4]), .exec_stb(exec_stb),
		.exec_wr(exec_wr), .exec_instr(exec_instr), .exec_data(exec_data), .trans_fail(trans_fail));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) if (exec_stb === 1'b1) n_exec <= n_exec + 1;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic run(input logic [15:0] tx, input int nbits);
		n0 = n_exec;
		u_hbs_spi_master.xfer(tx, nbits, rx, oe);
		u_hbs_spi_master.wait_clk(10);
		check(16'(so_oe), 16'h0000, "enable after frame");
	endtask : run
	// ==========================================================
	// Valid read of the identifier must carry and then clear a pending flag
	task automatic clear_flag(input logic flag);
		run(16'h0000, 16);
		check(16'(rx[8]), 16'(flag), "flag bit");
		check(16'(trans_fail), 16'h0000, "flag after sending");
	endtask : clear_flag
	task automatic test_codes;
		logic [5:0] ops [7];
		logic [7:0] rep [7];
		ops = '{6'h00, 6'h03, 6'h09, 6'h30, 6'h3c, 6'h28, 6'h18};
		rep = '{vals[0], vals[1], vals[2], vals[3], vals[4], 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) begin
			run({2'h0, ops[i], 8'hc3}, 16);
			check(oe, 16'h3fff, "enable mask");
			check(16'(rx[13:8]), 16'h002a, "verification byte");
			check(16'(rx[7:0]), 16'(rep[i]), "reply byte");
			check(16'(n_exec - n0), 16'h0001, "commit count");
			check({exec_wr, exec_instr}, {i > 4, 2'h0, ops[i]}, "commit instr");
			check(16'(exec_data), (i > 4) ? 16'h00c3 : 16'h0000, "commit data");
		end
	endtask : test_codes
	task automatic test_unused_and_addr;
		run(16'h0155, 16);
		check(16'(rx[7:0]), 16'h00ff, "unused reply");
		check({15'(n_exec - n0), trans_fail}, 16'h0001, "unused no commit");
		run(16'h4000, 16);
		check(oe, 16'h0000, "mismatch enable");
		check({15'(n_exec - n0), trans_fail}, 16'h0001, "mismatch flag kept");
		clear_flag(1'b1);
		clear_flag(1'b0);
	endtask : test_unused_and_addr
	task automatic test_count_and_busy;
		for (int n = 15; n <= 17; n += 2) begin
			run(16'h0000, n);
			check({15'(n_exec - n0), trans_fail}, 16'h0001, "bad count");
			clear_flag(1'b1);
		end
		proc_busy = 1'b1;
		run(16'h0000, 16);
		proc_busy = 1'b0;
		check({15'(n_exec - n0), trans_fail}, 16'h0001, "busy frame");
		clear_flag(1'b1);
	endtask : test_count_and_busy
	// ==========================================================
	// A cut frame that carries a pending flag keeps it; reset then clears it
	task automatic test_reset;
		run(16'h0155, 16);
		run(16'h0000, 15);
		check(16'(rx[8]), 16'h0001, "flag in cut frame");
		check(16'(trans_fail), 16'h0001, "flag kept by invalid frame");
		reset_n = 1'b0;
		u_hbs_spi_master.wait_clk(2);
		check({so_oe, trans_fail, exec_stb}, 16'h0000, "mid-run reset state");
		reset_n = 1'b1;
		u_hbs_spi_master.wait_clk(4);
		clear_flag(1'b0);
	endtask : test_reset
	// ==========================================================
	// About 42k mclk of frames are expected; the limit leaves margin
	initial begin
		#300_000;
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end
	initial begin
		reset_n = 1'b0;
		proc_busy = 1'b0;
		vals = '{8'ha5, 8'h3c, 8'h7e, 8'h96, 8'h41};
		bad_count = 0;
		num_checks = 0;
		n_exec = 0;
		repeat (2) @(posedge mclk);
		#1;
		check({so_oe, trans_fail}, 16'h0000, "reset state");
		reset_n = 1'b1;
		u_hbs_spi_master.wait_clk(4);
		test_codes();
		test_unused_and_addr();
		test_count_and_busy();
		test_reset();
		test_done();
	end
endmodule : hbs_spi_frame_tb_top
`default_nettype wire
